// ===== inc/pmsc_pkg.sv
package pmsc_pkg;
	// link clock synthesis: fractional steps per reference half-period
	localparam int REF_KHZ = 25000;
	localparam int TXC_100_KHZ = 25000;
	localparam int TXC_SER_KHZ = 10000;
	localparam int TXC_NIB_KHZ = 2500;
	localparam int ACC_MOD_I = 10;
	localparam logic [4:0] ACC_MOD = 5'(ACC_MOD_I);
	localparam logic [4:0] STEP_100 = 5'(ACC_MOD_I * TXC_100_KHZ / REF_KHZ);
	localparam logic [4:0] STEP_SER = 5'(ACC_MOD_I * TXC_SER_KHZ / REF_KHZ);
	localparam logic [4:0] STEP_NIB = 5'(ACC_MOD_I * TXC_NIB_KHZ / REF_KHZ);
	// strap capture: wait for the synchronisers to fill after release
	localparam logic [1:0] CAP_DELAY = 2'h2;
	localparam int R16_CODING_BIT = 15;
	localparam int R16_SCR_BIT = 14;
	localparam int R17_ADDR_MSB = 8;
	localparam int R17_ADDR_LSB = 4;
	localparam int R18_SER_BIT = 10;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// code groups
	localparam logic [4:0] SYM_IDLE = 5'h1F;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0D;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_HALT = 5'h04;
	localparam logic [3:0] PREAMBLE_NIB = 4'h5;
	localparam logic [10:0] SCR_SEED = 11'h7FF;
	// strap operating-mode codes
	localparam logic [3:0] OPM_AN_ALL_FC = 4'h0;
	localparam logic [3:0] OPM_AN_ALL = 4'h1;
	localparam logic [3:0] OPM_AN_100FD_FC = 4'h2;
	localparam logic [3:0] OPM_AN_100 = 4'h3;
	localparam logic [3:0] OPM_AN_10FD_FC = 4'h4;
	localparam logic [3:0] OPM_AN_10 = 4'h5;
	localparam logic [3:0] OPM_F_100FD = 4'h6;
	localparam logic [3:0] OPM_F_100HD = 4'h7;
	localparam logic [3:0] OPM_F_10FD = 4'h8;
	localparam logic [3:0] OPM_F_10HD = 4'h9;
	// advertised set {pause, 100fd, 100hd, 10fd, 10hd}
	localparam logic [4:0] ADV_ALL_FC = 5'h1F;
	localparam logic [4:0] ADV_ALL = 5'h0F;
	localparam logic [4:0] ADV_100FD_FC = 5'h18;
	localparam logic [4:0] ADV_100 = 5'h0C;
	localparam logic [4:0] ADV_10FD_FC = 5'h12;
	localparam logic [4:0] ADV_10 = 5'h03;
	localparam logic [4:0] ADV_NONE = 5'h00;

	typedef enum logic [1:0] {TX_IDLE, TX_SEND_K, TX_DATA, TX_SEND_R} pmsc_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_GOT_J, RX_DATA} pmsc_rx_e;

	function automatic logic [4:0] pmsc_enc(input logic [3:0] nib);
		logic [4:0] s;
		case (nib)
			4'h0: s = 5'h1E;
			4'h1: s = 5'h09;
			4'h2: s = 5'h14;
			4'h3: s = 5'h15;
			4'h4: s = 5'h0A;
			4'h5: s = 5'h0B;
			4'h6: s = 5'h0E;
			4'h7: s = 5'h0F;
			4'h8: s = 5'h12;
			4'h9: s = 5'h13;
			4'hA: s = 5'h16;
			4'hB: s = 5'h17;
			4'hC: s = 5'h1A;
			4'hD: s = 5'h1B;
			4'hE: s = 5'h1C;
			default: s = 5'h1D;
		endcase
		return s;
	endfunction

	// returns {valid, nibble}
	function automatic logic [4:0] pmsc_dec(input logic [4:0] sym);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (pmsc_enc(4'(i)) == sym) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	// five steps of x^11+x^9+1, returns {next state, key}
	function automatic logic [15:0] pmsc_scr(input logic [10:0] st);
		logic [10:0] s;
		logic [4:0] k;
		s = st;
		k = 5'h00;
		for (int i = 0; i < 5; i++) begin
			k[i] = s[10] ^ s[8];
			s = {s[9:0], k[i]};
		end
		return {s, k};
	endfunction

	// returns {an_enable, forced_100, forced_fdx, advertised set}
	function automatic logic [7:0] pmsc_opmode(input logic [3:0] code);
		logic [7:0] r;
		case (code)
			OPM_AN_ALL: r = {3'h4, ADV_ALL};
			OPM_AN_100FD_FC: r = {3'h4, ADV_100FD_FC};
			OPM_AN_100: r = {3'h4, ADV_100};
			OPM_AN_10FD_FC: r = {3'h4, ADV_10FD_FC};
			OPM_AN_10: r = {3'h4, ADV_10};
			OPM_F_100FD: r = {3'h3, ADV_NONE};
			OPM_F_100HD: r = {3'h2, ADV_NONE};
			OPM_F_10FD: r = {3'h1, ADV_NONE};
			OPM_F_10HD: r = {3'h0, ADV_NONE};
			default: r = {3'h4, ADV_ALL_FC};
		endcase
		return r;
	endfunction
endpackage

// ===== hdl/pmsc_top.sv
`timescale 1ns/1ps
module pmsc_top (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// strap and control pins
	input wire logic op_select_bit0,
	input wire logic op_select_bit1,
	input wire logic op_select_bit2,
	input wire logic op_select_bit3,
	input wire logic repeater_or_node_select,
	input wire logic alignment_bypass,
	input wire logic coding_bypass,
	input wire logic scrambler_bypass,
	input wire logic serial_ten_select,
	input wire logic mgmt_addr_bit0,
	input wire logic mgmt_addr_bit1,
	input wire logic mgmt_addr_bit2,
	input wire logic mgmt_addr_bit3,
	input wire logic mgmt_addr_bit4,
	input wire logic global_tristate,
	input wire logic test_select,
	// crystal reference
	input wire logic xtal_ref,
	// negotiation result
	input wire logic an_speed100,
	input wire logic an_full_duplex,
	// transmit side toward the mac
	output logic tx_clk,
	output logic tx_clk_oe,
	input wire logic [3:0] txd,
	input wire logic tx_en,
	input wire logic tx_er,
	// receive side toward the mac
	output logic rx_clk,
	output logic rx_clk_oe,
	output logic [3:0] rxd,
	output logic rxd_oe,
	output logic rx_dv,
	output logic rx_dv_oe,
	output logic rx_er,
	output logic rx_er_oe,
	output logic crs,
	output logic crs_oe,
	output logic col,
	output logic col_oe,
	output logic crystal_clock_out,
	output logic crystal_clock_out_oe,
	// line coder side
	output logic [4:0] line_tx_sym,
	output logic line_tx_valid,
	input wire logic [4:0] line_rx_sym,
	input wire logic line_rx_valid,
	input wire logic line_rx_active,
	// captured configuration
	output logic an_enable,
	output logic [4:0] adv_caps,
	output logic speed100,
	output logic full_duplex,
	output logic [15:0] reg16_strap,
	output logic [15:0] reg17_strap,
	output logic [15:0] reg18_strap,
	output logic [4:0] mgmt_addr,
	output logic mgmt_addr_zero,
	output logic test_active
);
	localparam int STRAP_W = 16;

	logic [STRAP_W-1:0] strap_s1_r, strap_s2_r;
	logic [5:0] mac_s1_r, mac_s2_r;
	logic [1:0] ctl_s1_r, ctl_s2_r;
	logic ref_s1_r, ref_s2_r, ref_s3_r;
	logic [1:0] cap_cnt_r;
	logic cap_done_r;
	logic [3:0] opm_r;
	logic repeater_r, align_bp_r, coding_bp_r, scr_bp_r, serial_r;
	logic [4:0] addr_r;
	logic tristate_s, test_s, tx_en_s, tx_er_s;
	logic [3:0] txd_s;
	logic [4:0] acc_r;
	logic lclk_r;
	logic oe_r;
	pmsc_pkg::pmsc_tx_e tx_st_r, tx_st_nxt;
	pmsc_pkg::pmsc_rx_e rx_st_r, rx_st_nxt;
	logic [10:0] tx_lfsr_r, rx_lfsr_r;
	logic [4:0] pn_nib_sym;
	logic [3:0] pn_nib_r, pn_nib_nxt;
	logic pn_dv_r, pn_dv_nxt, pn_er_r, pn_er_nxt;
	logic [4:0] tx100_sym;

	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!resetn) begin
			strap_s1_r <= '0;
			strap_s2_r <= '0;
			mac_s1_r <= '0;
			mac_s2_r <= '0;
			ctl_s1_r <= '0;
			ctl_s2_r <= '0;
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_s3_r <= 1'b0;
		end else if (ce) begin
			strap_s1_r <= {op_select_bit3, op_select_bit2, op_select_bit1, op_select_bit0,
				repeater_or_node_select, alignment_bypass, coding_bypass, scrambler_bypass,
				serial_ten_select, mgmt_addr_bit4, mgmt_addr_bit3, mgmt_addr_bit2, mgmt_addr_bit1,
				mgmt_addr_bit0, 2'h0};
			strap_s2_r <= strap_s1_r;
			mac_s1_r <= {tx_er, tx_en, txd};
			mac_s2_r <= mac_s1_r;
			ctl_s1_r <= {test_select, global_tristate};
			ctl_s2_r <= ctl_s1_r;
			ref_s1_r <= xtal_ref;
			ref_s2_r <= ref_s1_r;
			ref_s3_r <= ref_s2_r;
		end
	end

	assign tristate_s = ctl_s2_r[0];
	assign test_s = ctl_s2_r[1];
	assign txd_s = mac_s2_r[3:0];
	assign tx_en_s = mac_s2_r[4];
	assign tx_er_s = mac_s2_r[5];

	// one-time strap capture; later pin changes are ignored until next reset
	wire cap_now = !cap_done_r && (cap_cnt_r == pmsc_pkg::CAP_DELAY);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cap_cnt_r <= 2'h0;
			cap_done_r <= 1'b0;
			opm_r <= pmsc_pkg::OPM_AN_ALL_FC;
			{repeater_r, align_bp_r, coding_bp_r, scr_bp_r, serial_r} <= 5'h00;
			addr_r <= 5'h00;
		end else if (ce) begin
			if (!cap_done_r) begin
				cap_cnt_r <= cap_cnt_r + 2'h1;
			end
			if (cap_now) begin
				cap_done_r <= 1'b1;
				opm_r <= strap_s2_r[15:12];
				{repeater_r, align_bp_r, coding_bp_r, scr_bp_r, serial_r} <= strap_s2_r[11:7];
				addr_r <= strap_s2_r[6:2];
			end
		end
	end

	// mode decode and effective link settings
	wire [7:0] opm_dec = pmsc_pkg::pmsc_opmode(opm_r);
	wire speed_nxt = opm_dec[7] ? an_speed100 : opm_dec[6];
	wire fdx_nxt = opm_dec[7] ? an_full_duplex : opm_dec[5];
	wire serial_eff = serial_r && !speed100;
	wire bypass_raw = coding_bp_r || align_bp_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			an_enable <= 1'b0;
			adv_caps <= pmsc_pkg::ADV_NONE;
			speed100 <= 1'b0;
			full_duplex <= 1'b0;
			reg16_strap <= pmsc_pkg::REG_RESET;
			reg17_strap <= pmsc_pkg::REG_RESET;
			reg18_strap <= pmsc_pkg::REG_RESET;
			mgmt_addr <= 5'h00;
			mgmt_addr_zero <= 1'b0;
			test_active <= 1'b0;
			oe_r <= 1'b0;
		end else if (ce) begin
			an_enable <= opm_dec[7];
			adv_caps <= opm_dec[4:0];
			speed100 <= speed_nxt;
			full_duplex <= fdx_nxt;
			reg16_strap[pmsc_pkg::R16_CODING_BIT] <= coding_bp_r;
			reg16_strap[pmsc_pkg::R16_SCR_BIT] <= scr_bp_r;
			reg18_strap[pmsc_pkg::R18_SER_BIT] <= serial_r;
			reg17_strap[pmsc_pkg::R17_ADDR_MSB:pmsc_pkg::R17_ADDR_LSB] <=
				{addr_r[0], addr_r[1], addr_r[2], addr_r[3], addr_r[4]};
			mgmt_addr <= addr_r;
			mgmt_addr_zero <= cap_done_r && (addr_r == 5'h00);
			test_active <= test_s;
			oe_r <= !tristate_s;
		end
	end

	// one clock feeds both mac clocks; recovered receive timing is outside this block
	wire ref_edge = ref_s2_r ^ ref_s3_r;
	wire [4:0] step = speed100 ? pmsc_pkg::STEP_100 :
		(serial_eff ? pmsc_pkg::STEP_SER : pmsc_pkg::STEP_NIB);
	wire [4:0] acc_sum = acc_r + step;
	wire acc_wrap = ref_edge && (acc_sum >= pmsc_pkg::ACC_MOD);
	wire lclk_fall = acc_wrap && lclk_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			acc_r <= 5'h00;
			lclk_r <= 1'b0;
			crystal_clock_out <= 1'b0;
		end else if (ce) begin
			crystal_clock_out <= ref_s2_r;
			if (ref_edge) begin
				acc_r <= acc_wrap ? acc_sum - pmsc_pkg::ACC_MOD : acc_sum;
			end
			if (acc_wrap) begin
				lclk_r <= !lclk_r;
			end
		end
	end

	assign tx_clk = lclk_r;
	assign rx_clk = lclk_r;
	assign {tx_clk_oe, rx_clk_oe, rxd_oe, rx_dv_oe} = {4{oe_r}};
	assign {rx_er_oe, crs_oe, col_oe, crystal_clock_out_oe} = {4{oe_r}};

	// transmit: sampled on our falling edge, mid-way through the mac's period
	wire [15:0] tx_scr = pmsc_pkg::pmsc_scr(tx_lfsr_r);
	wire [4:0] tx_data_sym = tx_er_s ? pmsc_pkg::SYM_HALT : pmsc_pkg::pmsc_enc(txd_s);
	wire [4:0] tx_pre_scr = bypass_raw ? {tx_er_s, txd_s} : tx100_sym;
	wire [4:0] tx_line100 = scr_bp_r ? tx_pre_scr : tx_pre_scr ^ tx_scr[4:0];
	wire [4:0] tx_line10 = serial_eff ? {4'h0, txd_s[0]} : {1'b0, txd_s};

	always_comb begin
		tx_st_nxt = tx_st_r;
		tx100_sym = pmsc_pkg::SYM_IDLE;
		case (tx_st_r)
			pmsc_pkg::TX_IDLE: begin
				if (tx_en_s) begin
					tx100_sym = pmsc_pkg::SYM_J;
					tx_st_nxt = pmsc_pkg::TX_SEND_K;
				end
			end
			pmsc_pkg::TX_SEND_K: begin
				tx100_sym = pmsc_pkg::SYM_K;
				tx_st_nxt = pmsc_pkg::TX_DATA;
			end
			pmsc_pkg::TX_DATA: begin
				tx100_sym = tx_en_s ? tx_data_sym : pmsc_pkg::SYM_T;
				tx_st_nxt = tx_en_s ? pmsc_pkg::TX_DATA : pmsc_pkg::TX_SEND_R;
			end
			pmsc_pkg::TX_SEND_R: begin
				tx100_sym = pmsc_pkg::SYM_R;
				tx_st_nxt = pmsc_pkg::TX_IDLE;
			end
			default: tx_st_nxt = pmsc_pkg::TX_IDLE;
		endcase
		if (bypass_raw) begin
			tx_st_nxt = pmsc_pkg::TX_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_st_r <= pmsc_pkg::TX_IDLE;
			tx_lfsr_r <= pmsc_pkg::SCR_SEED;
			line_tx_sym <= pmsc_pkg::SYM_IDLE;
			line_tx_valid <= 1'b0;
		end else if (ce) begin
			line_tx_valid <= lclk_fall && (speed100 || tx_en_s);
			if (lclk_fall) begin
				line_tx_sym <= speed100 ? tx_line100 : tx_line10;
				if (speed100) begin
					tx_st_r <= tx_st_nxt;
					tx_lfsr_r <= tx_scr[15:5];
				end
			end
		end
	end

	// receive: test mode loops the transmit symbols back internally
	wire [4:0] rx_src_sym = test_active ? line_tx_sym : line_rx_sym;
	wire rx_src_valid = test_active ? line_tx_valid : line_rx_valid;
	wire rx_src_act = test_active ? tx_en_s : line_rx_active;
	wire [15:0] rx_scr = pmsc_pkg::pmsc_scr(rx_lfsr_r);
	wire [4:0] rx_plain = scr_bp_r ? rx_src_sym : rx_src_sym ^ rx_scr[4:0];
	wire [4:0] rx_dec = pmsc_pkg::pmsc_dec(rx_plain);
	wire rx_end = (rx_plain == pmsc_pkg::SYM_T) || (rx_plain == pmsc_pkg::SYM_IDLE);
	assign pn_nib_sym = serial_eff ? {4'h0, rx_src_sym[0]} : {1'b0, rx_src_sym[3:0]};

	always_comb begin
		rx_st_nxt = rx_st_r;
		pn_nib_nxt = pn_nib_r;
		pn_dv_nxt = pn_dv_r;
		pn_er_nxt = pn_er_r;
		if (rx_src_valid && !speed100) begin
			pn_nib_nxt = pn_nib_sym[3:0];
			pn_dv_nxt = rx_src_act;
			pn_er_nxt = 1'b0;
		end else if (rx_src_valid && bypass_raw) begin
			pn_nib_nxt = rx_plain[3:0];
			pn_er_nxt = rx_plain[4];
			pn_dv_nxt = rx_src_act;
		end else if (rx_src_valid) begin
			case (rx_st_r)
				pmsc_pkg::RX_IDLE: begin
					pn_dv_nxt = 1'b0;
					pn_er_nxt = 1'b0;
					if (rx_plain == pmsc_pkg::SYM_J) begin
						rx_st_nxt = pmsc_pkg::RX_GOT_J;
					end
				end
				pmsc_pkg::RX_GOT_J: begin
					if (rx_plain == pmsc_pkg::SYM_K) begin
						rx_st_nxt = pmsc_pkg::RX_DATA;
						pn_dv_nxt = 1'b1;
						pn_nib_nxt = pmsc_pkg::PREAMBLE_NIB;
					end else begin
						rx_st_nxt = pmsc_pkg::RX_IDLE;
					end
				end
				pmsc_pkg::RX_DATA: begin
					if (rx_end) begin
						rx_st_nxt = pmsc_pkg::RX_IDLE;
						pn_dv_nxt = 1'b0;
						pn_er_nxt = 1'b0;
					end else begin
						pn_nib_nxt = rx_dec[3:0];
						pn_er_nxt = !rx_dec[4];
					end
				end
				default: rx_st_nxt = pmsc_pkg::RX_IDLE;
			endcase
		end else if (!rx_src_act && !speed100) begin
			pn_dv_nxt = 1'b0;
		end
	end

	// carrier: transmit activity counts only in half-duplex node operation
	wire crs_nxt = rx_src_act || (tx_en_s && !full_duplex && !repeater_r && !test_active);
	wire col_nxt = !full_duplex && !test_active && rx_src_act && tx_en_s;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_st_r <= pmsc_pkg::RX_IDLE;
			rx_lfsr_r <= pmsc_pkg::SCR_SEED;
			{pn_nib_r, pn_dv_r, pn_er_r} <= 6'h00;
			{rxd, rx_dv, rx_er} <= 6'h00;
			crs <= 1'b0;
			col <= 1'b0;
		end else if (ce) begin
			rx_st_r <= rx_st_nxt;
			{pn_nib_r, pn_dv_r, pn_er_r} <= {pn_nib_nxt, pn_dv_nxt, pn_er_nxt};
			if (rx_src_valid && speed100) begin
				rx_lfsr_r <= rx_scr[15:5];
			end
			if (lclk_fall) begin
				{rxd, rx_dv, rx_er} <= {pn_nib_r, pn_dv_r, pn_er_r};
			end
			crs <= crs_nxt;
			col <= col_nxt;
		end
	end
endmodule

// ===== tb/pmsc_properties.sv
`timescale 1ns/1ps
module pmsc_properties (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// pins and clocks
	input wire logic global_tristate,
	input wire logic xtal_ref,
	input wire logic tx_clk,
	input wire logic rx_clk,
	input wire logic tx_clk_oe,
	input wire logic rx_clk_oe,
	input wire logic rxd_oe,
	input wire logic crystal_clock_out,
	input wire logic crystal_clock_out_oe,
	// receive outputs
	input wire logic [3:0] rxd,
	input wire logic rx_dv,
	input wire logic rx_er,
	// line side
	input wire logic line_tx_valid,
	// captured configuration
	input wire logic speed100,
	input wire logic an_enable,
	input wire logic [4:0] adv_caps,
	input wire logic [15:0] reg16_strap,
	input wire logic [15:0] reg17_strap,
	input wire logic [15:0] reg18_strap,
	input wire logic [4:0] mgmt_addr
);
	logic [3:0] run_r;
	// saturating age since release, keeps $past away from reset values
	always_ff @(posedge clk) begin
		if (!resetn)
			run_r <= 4'h0;
		else if (run_r != 4'hF)
			run_r <= run_r + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	tristate_float_a: assert property (global_tristate [*5] |-> !(tx_clk_oe || rx_clk_oe || rxd_oe || crystal_clock_out_oe))
		else $error("outputs still driven under tristate");
	tx_pulse_a: assert property (line_tx_valid |-> $fell(tx_clk) ##1 !line_tx_valid)
		else $error("symbol strobe off the clock fall");
	tx_steady_a: assert property (speed100 && $past(speed100) && $fell(tx_clk) |-> line_tx_valid)
		else $error("fast mode skipped a symbol");
	tx_clk_live_a: assert property (run_r == 4'hF |-> ##[1:60] $changed(tx_clk))
		else $error("transmit clock stopped");
	rx_clk_live_a: assert property (run_r == 4'hF |-> ##[1:60] $changed(rx_clk))
		else $error("receive clock stopped");
	rx_on_fall_a: assert property (!$fell(tx_clk) |-> $stable({rxd, rx_dv, rx_er}))
		else $error("receive outputs moved off the clock fall");
	xtal_copy_a: assert property (run_r > 4'h4 |-> crystal_clock_out == $past(xtal_ref, 3))
		else $error("crystal copy wrong");
	addr_map_a: assert property (run_r > 4'h8 |-> reg17_strap == {7'h00, mgmt_addr[0], mgmt_addr[1],
		mgmt_addr[2], mgmt_addr[3], mgmt_addr[4], 4'h0}) else $error("address image wrong");
	forced_adv_a: assert property (run_r > 4'h8 && !an_enable |-> adv_caps == 5'h00)
		else $error("forced mode advertises");
	cfg_hold_a: assert property (run_r > 4'h8 |-> $stable({an_enable, adv_caps, reg16_strap, reg17_strap,
		reg18_strap, mgmt_addr})) else $error("captured straps changed");
endmodule

// ===== tb/pmsc_mac_model.sv
`timescale 1ns/1ps
module pmsc_mac_model (
	// clocks
	input wire logic clk,
	input wire logic tx_clk,
	input wire logic rx_clk,
	// receive side
	input wire logic [3:0] rxd,
	input wire logic rx_dv,
	input wire logic rx_er,
	// transmit side
	output logic [3:0] txd,
	output logic tx_en,
	output logic tx_er
);
	logic [4:0] txq[$];
	logic [4:0] rxq[$];
	logic [4:0] cur;
	logic tx_prev = 1'b0;
	logic rx_prev = 1'b0;
	initial begin
		txd = 4'h0;
		tx_en = 1'b0;
		tx_er = 1'b0;
	end
	// edges found on the system clock so updates never race the phy sampling
	always @(negedge clk) begin
		if (tx_clk && !tx_prev) begin
			if (txq.size() > 0) begin
				cur = txq.pop_front();
				txd <= cur[3:0];
				tx_er <= cur[4];
				tx_en <= 1'b1;
			end else begin
				tx_en <= 1'b0;
				tx_er <= 1'b0;
				txd <= ~txd; // idle data never repeats a nibble
			end
		end
		if (rx_clk && !rx_prev && rx_dv)
			rxq.push_back({rx_er, rxd});
		tx_prev <= tx_clk;
		rx_prev <= rx_clk;
	end
endmodule

// ===== tb/pmsc_top_tb_top.sv
`timescale 1ns/1ps
module pmsc_top_tb_top;
	logic clk, resetn, ce, op_select_bit0, op_select_bit1, op_select_bit2, op_select_bit3;
	logic repeater_or_node_select, alignment_bypass, coding_bypass, scrambler_bypass, serial_ten_select;
	logic mgmt_addr_bit0, mgmt_addr_bit1, mgmt_addr_bit2, mgmt_addr_bit3, mgmt_addr_bit4;
	logic global_tristate, test_select, xtal_ref, an_speed100, an_full_duplex, line_rx_valid, line_rx_active;
	logic [4:0] line_rx_sym, line_tx_sym, adv_caps, mgmt_addr;
	logic [3:0] txd, rxd;
	logic tx_en, tx_er, tx_clk, tx_clk_oe, rx_clk, rx_clk_oe, rxd_oe, rx_dv, rx_dv_oe, rx_er, rx_er_oe;
	logic crs, crs_oe, col, col_oe, crystal_clock_out, crystal_clock_out_oe, line_tx_valid;
	logic an_enable, speed100, full_duplex, mgmt_addr_zero, test_active;
	logic [15:0] reg16_strap, reg17_strap, reg18_strap;
	logic [7:0] oe_all;
	logic [4:0] seen[$];
	int fails = 0;
	int checks_done = 0;
	// code 1010 behaves as 0000
	localparam logic [4:0] ADV_T [11] = '{5'h1F, 5'h0F, 5'h18, 5'h0C, 5'h12, 5'h03, 5'h00, 5'h00, 5'h00, 5'h00, 5'h1F};
	localparam logic [4:0] SEQ [7] = '{5'h18, 5'h11, 5'h15, 5'h16, 5'h04, 5'h0D, 5'h07};
	localparam logic [4:0] RXS [3] = '{5'h05, 5'h03, 5'h0A};
	assign oe_all = {tx_clk_oe, rx_clk_oe, rxd_oe, rx_dv_oe, rx_er_oe, crs_oe, col_oe, crystal_clock_out_oe};
	pmsc_top dut (.*);
	pmsc_mac_model mac (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// free-running reference, phase unrelated to clk
	initial begin
		xtal_ref = 1'b0;
		#7.3;
		forever #100 xtal_ref = ~xtal_ref;
	end
	always @(negedge clk)
		if (line_tx_valid === 1'b1 && line_tx_sym !== 5'h1F)
			seen.push_back(line_tx_sym);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// fl = {alignment, coding, scrambler, serial}
	task automatic boot(input logic [3:0] op, input logic [4:0] adr, input logic [3:0] fl);
		{op_select_bit3, op_select_bit2, op_select_bit1, op_select_bit0} = op;
		{mgmt_addr_bit4, mgmt_addr_bit3, mgmt_addr_bit2, mgmt_addr_bit1, mgmt_addr_bit0} = adr;
		{alignment_bypass, coding_bypass, scrambler_bypass, serial_ten_select} = fl;
		repeater_or_node_select = fl[1];
		an_full_duplex = fl[0];
		resetn = 1'b0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (12) @(negedge clk);
	endtask
	// jitter of the fractional divider allows one fall either way
	task automatic falls(input int exp);
		int n;
		logic p;
		n = 0;
		p = tx_clk;
		repeat (800) begin
			@(negedge clk);
			if (p === 1'b1 && tx_clk === 1'b0)
				n++;
			p = tx_clk;
		end
		chk(16'(n >= exp - 1 && n <= exp + 1), 16'h0001);
	endtask
	// carrier and collision with transmit only, then with receive activity as well
	task automatic carrier(input logic [3:0] op, input logic [3:0] fl, input logic [1:0] tx_only,
		input logic [1:0] both);
		line_rx_active = 1'b0;
		boot(op, 5'h00, fl);
		mac.txq = '{5'h05, 5'h05, 5'h05, 5'h05};
		repeat (16) @(negedge clk);
		chk(16'({crs, col}), 16'(tx_only));
		line_rx_active = 1'b1;
		repeat (3) @(negedge clk);
		chk(16'({crs, col}), 16'(both));
	endtask
	task automatic final_report();
		$display("mismatches %0d, comparisons %0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		final_report();
	end
	initial begin
		{ce, global_tristate, test_select, an_speed100, line_rx_valid, line_rx_active} = 6'b100100;
		line_rx_sym = 5'h00;
		for (int i = 0; i <= 10; i++) begin
			logic [4:0] a;
			logic an;
			a = 5'(i * 7);
			an = (i < 6) || (i == 10);
			boot(4'(i), a, 4'(i));
			chk(16'(adv_caps), 16'(ADV_T[i]));
			chk(16'({an_enable, speed100, full_duplex}), 16'({an, an || i < 8, an ? i[0] : !i[0]}));
			chk(reg16_strap, {i[2], i[1], 14'h0000});
			chk(reg18_strap, 16'(i[0]) << 10);
			chk(reg17_strap, 16'({a[0], a[1], a[2], a[3], a[4]}) << 4);
			chk(16'({mgmt_addr_zero, mgmt_addr}), 16'({a == 5'h00, a}));
			falls(an || i < 8 ? 100 : (i[0] ? 40 : 10));
		end
		{op_select_bit2, op_select_bit1, mgmt_addr_bit4} = 3'b111;
		repeat (10) @(negedge clk);
		chk(16'({an_enable, adv_caps, mgmt_addr}), 16'({1'b1, 5'h1F, 5'h06}));
		global_tristate = 1'b1;
		repeat (6) @(negedge clk);
		chk(16'(oe_all), 16'h0000);
		global_tristate = 1'b0;
		repeat (6) @(negedge clk);
		chk(16'(oe_all), 16'h00FF);
		test_select = 1'b1;
		boot(4'h6, 5'h00, 4'h2);
		chk(16'(test_active), 16'h0001);
		seen.delete();
		mac.rxq.delete();
		mac.txq = '{5'h05, 5'h05, 5'h03, 5'h0A, 5'h10};
		repeat (200) @(negedge clk);
		chk(16'(seen.size()), 16'h0007);
		for (int k = 0; k < 7; k++)
			chk(16'(seen[k]), 16'(SEQ[k]));
		chk(16'(mac.rxq.size()), 16'h0004);
		for (int k = 0; k < 3; k++)
			chk(16'(mac.rxq[k]), 16'(RXS[k]));
		chk(16'(mac.rxq[3][4]), 16'h0001);
		test_select = 1'b0;
		// half-duplex node: transmit alone raises carrier, both directions collide
		carrier(4'h7, 4'h0, 2'h2, 2'h3);
		// full-duplex repeater: carrier only from receive, never a collision
		carrier(4'h6, 4'h2, 2'h0, 2'h2);
		line_rx_active = 1'b0;
		final_report();
	end
endmodule
bind pmsc_top pmsc_properties u_props (.*);
